// ---- logic/risc_regs.svh ----
`ifndef RISC_REGS_SVH
`define RISC_REGS_SVH
// Behaviour
// - each input has a two-bit rank, 00 lowest through 11 highest.
// - an input ranked 00 is never picked by automatic switching.
// - on equal rank the automatic selector prefers input 0 over input 1.
// - with ref_loss_mask at 0 lock status fails on pll loss of lock or on inactivity of the selected input.
// - with ref_loss_mask at 1 only pll loss of lock sets the lock status failure.
// - ref_loss_mask at 1 also keeps a reference loss off the gpio failure output when gpio reports failures.
// - revertive_enable only acts in the automatic modes and does nothing when mode bit 0 is 0.
// - with revertive_enable at 0 a re-validated unselected input leaves the selection alone.
// - with revertive_enable at 1 a re-validated unselected input of higher rank than the active one is switched to.
// - selection_mode encodes 00 manual, 01 auto, 10 short-term holdover, 11 auto with holdover.
// - in manual modes input select 00 picks input 0 and 01 input 1, 10 and 11 reserved.
// - in automatic modes a state machine picks from the loss flags and the ranks.
// - a gpio input selection overrides the mode field selection.

// ****************************************
// register offsets
// ****************************************
`define RISC_ADDR_RANK 8'h34
`define RISC_ADDR_MODE 8'h35
`define RISC_ADDR_HCNT 8'h36
`define RISC_ADDR_HDIV 8'h37

// ****************************************
// field positions and masks
// ****************************************
`define RISC_RANK0_LSB 6
`define RISC_RANK1_LSB 4
`define RISC_RANK_MASK 8'hF0
`define RISC_MASK_BIT 6
`define RISC_REVERT_BIT 5
`define RISC_MODE_LSB 2
`define RISC_SEL_LSB 0
`define RISC_MODE_MASK 8'h6F
`define RISC_HDIV_MASK 8'hC3

// ****************************************
// reset values
// ****************************************
`define RISC_RANK_RST 8'hE0
`define RISC_MODE_RST 8'h00
`define RISC_HCNT_RST 8'h80
`define RISC_HDIV_RST 8'h00
`endif

// ---- logic/risc_pkg.sv ----
package risc_pkg;
  typedef logic [1:0] risc_rank_t;
  typedef enum logic [1:0] {
    RISC_MANUAL,
    RISC_AUTO,
    RISC_SHORT_HOLD,
    RISC_AUTO_HOLD
  } risc_mode_e;
  typedef enum {
    RISC_ST_MANUAL,
    RISC_ST_ON0,
    RISC_ST_ON1,
    RISC_ST_NONE
  } risc_state_e;
endpackage

// ---- logic/risc_sync.sv ----
`timescale 1ns/1ps
module risc_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] d,
  output logic [4:0] q
);
  logic [4:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 5'h00;
      q <= 5'h00;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// ---- logic/risc_switch.sv ----
`timescale 1ns/1ps
`include "risc_regs.svh"
module risc_switch (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [1:0] input_valid,
  input wire logic pll_locked,
  input wire logic gpio_sel_en,
  input wire logic gpio_sel,
  input wire logic gpio_fail_report,
  output logic ref_select,
  output logic ref_active,
  output logic pll_lock_state,
  output logic pll_lock_latched,
  output logic gpio_fail,
  output logic revert_event
);
  import risc_pkg::*;

  // ****************************************
  // input synchronisers
  // ****************************************
  // pins and the pll lock come from other domains; apart from gpio_fail_report nothing reads them before two flops
  logic [4:0] sync_q;
  risc_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({input_valid, pll_locked, gpio_sel_en, gpio_sel}),
    .q(sync_q)
  );

  logic [1:0] valid_s;
  logic lock_s;
  logic gsel_en_s;
  logic gsel_s;
  assign valid_s = sync_q[4:3];
  assign lock_s = sync_q[2];
  assign gsel_en_s = sync_q[1];
  assign gsel_s = sync_q[0];

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] input_priority_config;
  logic [7:0] switch_mode_control;
  logic [7:0] holdoff_count_period;
  logic [7:0] holdoff_divider_config;

  wire wr_rank = reg_wr && (reg_addr == `RISC_ADDR_RANK);
  wire wr_mode = reg_wr && (reg_addr == `RISC_ADDR_MODE);
  wire wr_hcnt = reg_wr && (reg_addr == `RISC_ADDR_HCNT);
  wire wr_hdiv = reg_wr && (reg_addr == `RISC_ADDR_HDIV);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      input_priority_config <= `RISC_RANK_RST;
      switch_mode_control <= `RISC_MODE_RST;
      holdoff_count_period <= `RISC_HCNT_RST;
      holdoff_divider_config <= `RISC_HDIV_RST;
    end else begin
      if (wr_rank) input_priority_config <= reg_wdata & `RISC_RANK_MASK;
      if (wr_mode) switch_mode_control <= reg_wdata & `RISC_MODE_MASK;
      if (wr_hcnt) holdoff_count_period <= reg_wdata;
      if (wr_hdiv) holdoff_divider_config <= reg_wdata & `RISC_HDIV_MASK;
    end
  end

  // ****************************************
  // field decode
  // ****************************************
  risc_rank_t rank0;
  risc_rank_t rank1;
  risc_mode_e selection_mode;
  logic [1:0] input_select;
  logic ref_loss_mask;
  logic revertive_enable;
  logic auto_mode;
  assign rank0 = input_priority_config[`RISC_RANK0_LSB +: 2];
  assign rank1 = input_priority_config[`RISC_RANK1_LSB +: 2];
  assign selection_mode = risc_mode_e'(switch_mode_control[`RISC_MODE_LSB +: 2]);
  assign input_select = switch_mode_control[`RISC_SEL_LSB +: 2];
  assign ref_loss_mask = switch_mode_control[`RISC_MASK_BIT];
  assign revertive_enable = switch_mode_control[`RISC_REVERT_BIT];
  // short-term holdover takes the manual path; no holdover timing lives in this block
  assign auto_mode = (selection_mode == RISC_AUTO) || (selection_mode == RISC_AUTO_HOLD);

  // an input counts as a candidate only when valid and ranked above zero
  function automatic logic eligible(input logic vld, input risc_rank_t rk);
    return vld && (rk != 2'b00);
  endfunction

  // best candidate; ties go to input 0
  function automatic logic pick_best(input logic [1:0] vld, input risc_rank_t r0, input risc_rank_t r1);
    logic e0;
    logic e1;
    e0 = eligible(vld[0], r0);
    e1 = eligible(vld[1], r1);
    if (e0 && e1) return (r1 > r0) ? 1'b1 : 1'b0;
    return e1 && !e0;
  endfunction

  logic any_eligible;
  logic best;
  assign any_eligible = eligible(valid_s[0], rank0) || eligible(valid_s[1], rank1);
  assign best = pick_best(valid_s, rank0, rank1);

  // state the automatic selector settles on for the present flags and ranks
  function automatic risc_state_e auto_pick(input logic any_ok, input logic pick_one);
    if (!any_ok) return RISC_ST_NONE;
    if (pick_one) return RISC_ST_ON1;
    return RISC_ST_ON0;
  endfunction

  risc_state_e pick_state;
  assign pick_state = auto_pick(any_eligible, best);

  // ****************************************
  // automatic selection state machine
  // ****************************************
  risc_state_e state;
  risc_state_e next_state;
  logic [1:0] valid_d;
  logic [1:0] revalid;
  logic cur_sel;
  logic cur_ok;
  logic cur_rank_lower;
  logic do_revert;

  // valid_d resets low, so a flag valid at release reads as a rise; harmless, reset leaves the selector manual
  assign revalid = valid_s & ~valid_d;
  assign cur_sel = (state == RISC_ST_ON1);
  assign cur_ok = valid_s[cur_sel];
  assign cur_rank_lower = cur_sel ? (rank0 > rank1) : (rank1 > rank0);
  // only the non-selected input's rise can trigger a revert
  assign do_revert = auto_mode && revertive_enable && revalid[!cur_sel] &&
                     eligible(valid_s[!cur_sel], cur_sel ? rank0 : rank1) && cur_rank_lower;

  always_comb begin
    next_state = state;
    unique case (state)
      RISC_ST_MANUAL: begin
        if (auto_mode) next_state = pick_state;
      end
      RISC_ST_ON0, RISC_ST_ON1: begin
        if (!auto_mode) next_state = RISC_ST_MANUAL;
        else if (!cur_ok || !eligible(cur_ok, cur_sel ? rank1 : rank0) || do_revert) begin
          next_state = pick_state;
        end
      end
      RISC_ST_NONE: begin
        if (!auto_mode) next_state = RISC_ST_MANUAL;
        else if (any_eligible) next_state = pick_state;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= RISC_ST_MANUAL;
      valid_d <= 2'b00;
    end else begin
      state <= next_state;
      valid_d <= valid_s;
    end
  end

  // ****************************************
  // selected reference and status
  // ****************************************
  logic next_sel;
  logic next_active;
  logic ref_lost;
  logic next_lock_fail;
  // reserved select codes fall back to input 0 in manual mode
  assign next_sel = gsel_en_s ? gsel_s :
                    auto_mode ? (next_state == RISC_ST_ON1) : (input_select == 2'b01);
  assign next_active = gsel_en_s || !auto_mode || (next_state != RISC_ST_NONE);
  assign ref_lost = !valid_s[ref_select] || !ref_active;
  assign next_lock_fail = !lock_s || (!ref_loss_mask && ref_lost);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_select <= 1'b0;
      ref_active <= 1'b0;
      pll_lock_state <= 1'b0;
      pll_lock_latched <= 1'b0;
      gpio_fail <= 1'b0;
      revert_event <= 1'b0;
    end else begin
      ref_select <= next_sel;
      ref_active <= next_active;
      pll_lock_state <= !next_lock_fail;
      // sticky: set on any failure, only reset clears it
      pll_lock_latched <= pll_lock_latched | next_lock_fail;
      // same failure term as the lock status, so while gpio_fail_report is high the pin and the status never disagree
      gpio_fail <= gpio_fail_report && next_lock_fail;
      revert_event <= do_revert;
    end
  end

  // ****************************************
  // read back
  // ****************************************
  logic [7:0] next_rdata;
  // read data leaves a flop like every other output; it follows reg_addr one edge later
  always_comb begin
    unique case (reg_addr)
      `RISC_ADDR_RANK: next_rdata = input_priority_config;
      `RISC_ADDR_MODE: next_rdata = switch_mode_control;
      `RISC_ADDR_HCNT: next_rdata = holdoff_count_period;
      `RISC_ADDR_HDIV: next_rdata = holdoff_divider_config;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end
endmodule

// ---- verification/risc_switch_checker.sv ----
`timescale 1ns/1ps
// ****************************************
// port checker
// ****************************************
module risc_switch_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic pll_locked,
  input wire logic gpio_fail_report,
  input wire logic pll_lock_state,
  input wire logic pll_lock_latched,
  input wire logic gpio_fail,
  input wire logic revert_event
);
  logic [7:0] mode_q;
  // only the mask, revertive and mode bit 0 (bit 2) of 0x35 matter here, so a raw shadow is enough
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      mode_q <= 8'h00;
    else if (reg_wr && reg_addr == 8'h35)
      mode_q <= reg_wdata;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_fail_out;
    ##3 !pll_lock_state;
  endsequence
  // read data is registered, so it answers the address of the previous edge
  property p_rsv_rank; $past(reg_addr) == 8'h34 |-> reg_rdata[3:0] == 4'h0; endproperty
  a_rsv_rank: assert property (p_rsv_rank) else $error("rank reserved bits nonzero");
  property p_rsv_mode; $past(reg_addr) == 8'h35 |-> !reg_rdata[7] && !reg_rdata[4]; endproperty
  a_rsv_mode: assert property (p_rsv_mode) else $error("mode reserved bits nonzero");
  property p_unmapped; $past(reg_addr[7:2]) != 6'h0D |-> reg_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  property p_lock_fail; !pll_locked |-> s_fail_out; endproperty
  a_lock_fail: assert property (p_lock_fail) else $error("loss of lock not shown");
  property p_mask_lock; $past(mode_q[6]) && $past(pll_locked, 3) |-> pll_lock_state; endproperty
  a_mask_lock: assert property (p_mask_lock) else $error("masked loss still fails");
  property p_latch_set; !pll_lock_state |-> ##[0:3] pll_lock_latched; endproperty
  a_latch_set: assert property (p_latch_set) else $error("failure not latched");
  property p_latch_hold; pll_lock_latched |=> pll_lock_latched; endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched flag dropped");
  property p_gpio_gate; gpio_fail |-> !pll_lock_state && $past(gpio_fail_report); endproperty
  a_gpio_gate: assert property (p_gpio_gate) else $error("gpio failure without cause");
  property p_rev_pulse; revert_event |=> !revert_event; endproperty
  a_rev_pulse: assert property (p_rev_pulse) else $error("revert pulse too long");
  property p_rev_auto; revert_event |-> $past(mode_q[2]) && $past(mode_q[5]); endproperty
  a_rev_auto: assert property (p_rev_auto) else $error("revert outside auto or disabled");
endmodule
bind risc_switch risc_switch_checker chk_u (.clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .pll_locked,
  .gpio_fail_report, .pll_lock_state, .pll_lock_latched, .gpio_fail, .revert_event);

// ---- verification/risc_switch_tb.sv ----
`timescale 1ns/1ps
// ****************************************
// bench
// ****************************************
module risc_switch_tb;
  logic clk = 0, rst_n = 0, reg_wr = 0, pll_locked = 0, gpio_sel_en = 0, gpio_sel = 0, rep = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [1:0] input_valid = 2'h3;
  logic ref_select, ref_active, pll_lock_state, pll_lock_latched, gpio_fail, revert_event;
  int failures = 0, n_compared = 0, n_rev = 0;
  always #4 clk = ~clk;
  always @(posedge clk) n_rev <= n_rev + int'(revert_event === 1'b1);
  risc_switch dut_u (.clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .input_valid, .pll_locked,
    .gpio_sel_en, .gpio_sel, .gpio_fail_report(rep), .ref_select, .ref_active, .pll_lock_state,
    .pll_lock_latched, .gpio_fail, .revert_event);
  task automatic stop_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge clk);
    reg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_addr = a;
    // read data is registered: it stands after the next rising edge
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask
  task automatic settle();
    repeat (5) @(negedge clk);
  endtask
  // returns {active, select}; equal rank goes to input 0, rank 0 never picked
  function automatic logic [1:0] pick(input logic [7:0] pr, input logic [1:0] v);
    logic c0, c1;
    c0 = v[0] && pr[7:6] != 2'h0;
    c1 = v[1] && pr[5:4] != 2'h0;
    if (c0 && (!c1 || pr[7:6] >= pr[5:4]))
      return 2'b10;
    return c1 ? 2'b11 : 2'b00;
  endfunction
  initial begin
    #400000;
    failures++;
    stop_test();
  end
  initial begin
    logic [7:0] pr, d;
    logic [1:0] e;
    int b;
    void'($urandom(32'h16D89167));
    repeat (5) @(negedge clk);
    rst_n = 1;
    rd(8'h34, 8'hE0);
    rd(8'h35, 8'h00);
    rd(8'h36, 8'h80);
    rd(8'h37, 8'h00);
    for (int i = 0; i < 12; i++) begin
      d = 8'($urandom);
      wr({6'h0D, 2'(i)}, d);
      rd({6'h0D, 2'(i)}, d & (i % 4 == 0 ? 8'hF0 : i % 4 == 1 ? 8'h6F : i % 4 == 2 ? 8'hFF : 8'hC3));
    end
    wr(8'h38, 8'hFF);
    rd(8'h38, 8'h00);
    wr(8'h34, 8'hE0);
    for (int s = 0; s < 8; s++) begin
      wr(8'h35, 8'(s / 4 * 8 + s % 4));
      settle();
      chk({7'h00, ref_select}, {7'h00, s % 4 == 1});
    end
    gpio_sel_en = 1;
    for (int g = 0; g < 2; g++) begin
      gpio_sel = g[0];
      wr(8'h35, 8'(1 - g));
      settle();
      chk({7'h00, ref_select}, {7'h00, g[0]});
    end
    gpio_sel_en = 0;
    // each trial starts from manual so the automatic pick does not depend on history
    for (int i = 0; i < 24; i++) begin
      pr = i < 2 ? (i == 1 ? 8'h30 : 8'hF0) : 8'($urandom) & 8'hF0;
      input_valid = i < 2 ? 2'h3 : 2'($urandom);
      wr(8'h34, pr);
      wr(8'h35, 8'h00);
      settle();
      wr(8'h35, i % 2 == 1 ? 8'h0D : 8'h05);
      settle();
      e = pick(pr, input_valid);
      chk({7'h00, ref_active}, {7'h00, e[1]});
      if (e[1])
        chk({7'h00, ref_select}, {7'h00, e[0]});
    end
    wr(8'h34, 8'hE0);
    input_valid = 2'h3;
    for (int r = 0; r < 2; r++) begin
      wr(8'h35, 8'h00);
      settle();
      wr(8'h35, r == 1 ? 8'h24 : 8'h04);
      settle();
      b = n_rev;
      input_valid = 2'h2;
      settle();
      chk({7'h00, ref_select}, 8'h01);
      input_valid = 2'h3;
      settle();
      chk({7'h00, ref_select}, {7'h00, r == 0});
      chk(8'(n_rev - b), 8'(r));
    end
    b = n_rev;
    input_valid = 2'h1;
    settle();
    input_valid = 2'h3;
    settle();
    chk({7'h00, ref_select}, 8'h00);
    wr(8'h35, 8'h29);
    settle();
    input_valid = 2'h2;
    settle();
    input_valid = 2'h3;
    settle();
    chk({7'h00, ref_select}, 8'h01);
    chk(8'(n_rev - b), 8'h00);
    for (int k = 0; k < 8; k++) begin
      wr(8'h35, k[2] ? 8'h40 : 8'h00);
      input_valid = {1'b1, k[1]};
      pll_locked = k[0];
      rep = k[1] | !k[0];
      settle();
      chk({7'h00, pll_lock_state}, {7'h00, k[0] && (k[2] || k[1])});
      chk({7'h00, gpio_fail}, {7'h00, !(k[0] && (k[2] || k[1])) && rep});
    end
    chk({7'h00, pll_lock_latched}, 8'h01);
    stop_test();
  end
endmodule
